// ### common/dp_sram_pkg.sv
package dp_sram_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_PS = 25000;
   // Timing figures in ns, cycle counts derived (least times round up)
   localparam int ADDR_SETUP_NS = 0;
   localparam int WRITE_PULSE_NS = 12;
   localparam int FLOAT_DELAY_NS = 10;
   localparam int DATA_SETUP_NS = 10;
   localparam int ACCESS_NS = 15;
   localparam int FLOW_NS = 25;
   localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int FLOAT_SETUP_CYC =
      ((FLOAT_DELAY_NS + DATA_SETUP_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ACCESS_CYC = ((ACCESS_NS + 5) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int FLOW_CYC = (FLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
endpackage : dp_sram_pkg

// ### rtl/dp_sram_host.sv
`timescale 1ns/1ps
`default_nettype none
module dp_sram_host
   import dp_sram_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              req_valid,
   input  wire logic              req_write,
   input  wire logic              req_hold_drive,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_rdata,
   output logic [ADDR_W-1:0]      port_addr_lines,
   output logic                   port_sel_n,
   output logic                   port_we_n,
   output logic                   port_oe_n,
   input  wire logic [DATA_W-1:0] port_data_in,
   output logic [DATA_W-1:0]      port_data_out,
   output logic                   port_data_oe_n
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      IDLE  = 3'h0,
      SETUP = 3'h1,
      RD    = 3'h3,
      WR    = 3'h2,
      DONE  = 3'h6
   } state_e;

   typedef struct packed {
      state_e            st;
      logic [CNT_W-1:0]  cnt;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              sel_n;
      logic              we_n;
      logic              oe_n;
      logic              drv_n;
      logic              rv;
      logic [DATA_W-1:0] rdata;
   } ctl_s;

   localparam ctl_s CTL_RST = '{st: IDLE, cnt: CNT_RST, wr: 1'b0, addr: '0, wdata: '0,
                                sel_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, drv_n: 1'b1,
                                rv: 1'b0, rdata: '0};

   logic                  rst_s1_r;
   logic                  rst_s2_r;
   logic [DATA_W-1:0]     din_s1_r;
   logic [DATA_W-1:0]     din_s2_r;
   ctl_s                  ctl_r;
   ctl_s                  ctl_nxt;

   // ------------------------------------------------------------
   // Reset release and pin synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
      begin
         din_s1_r <= '0;
         din_s2_r <= '0;
      end
      else
      begin
         din_s1_r <= port_data_in;
         din_s2_r <= din_s1_r;
      end
   end

   // ------------------------------------------------------------
   // Access sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      ctl_nxt = ctl_r;
      ctl_nxt.rv = 1'b0;
      case (ctl_r.st)
         IDLE:
         begin
            if (req_valid)
            begin
               // Address moves only with strobe and select high
               ctl_nxt.addr = req_addr;
               ctl_nxt.wdata = req_wdata;
               ctl_nxt.wr = req_write;
               ctl_nxt.we_n = 1'b1;
               ctl_nxt.st = SETUP;
            end
         end
         SETUP:
         begin
            ctl_nxt.sel_n = 1'b0;
            ctl_nxt.cnt = CNT_RST;
            if (ctl_r.wr)
            begin
               // Strobe falls one cycle after address: setup beyond zero
               ctl_nxt.we_n = 1'b0;
               ctl_nxt.oe_n = req_hold_drive ? 1'b0 : 1'b1;
               ctl_nxt.drv_n = 1'b0;
               ctl_nxt.st = WR;
            end
            else
            begin
               ctl_nxt.we_n = 1'b1;
               ctl_nxt.oe_n = 1'b0;
               ctl_nxt.drv_n = 1'b1;
               ctl_nxt.st = RD;
            end
         end
         RD:
         begin
            ctl_nxt.cnt = ctl_r.cnt + 4'h1;
            // Two extra cycles cover the pin synchroniser latency
            if (ctl_r.cnt == CNT_W'(ACCESS_CYC + 2))
            begin
               ctl_nxt.rdata = din_s2_r;
               ctl_nxt.rv = 1'b1;
               ctl_nxt.sel_n = 1'b1;
               ctl_nxt.oe_n = 1'b1;
               ctl_nxt.st = DONE;
            end
         end
         WR:
         begin
            ctl_nxt.cnt = ctl_r.cnt + 4'h1;
            // Output drive low needs float time plus data setup
            if (ctl_r.cnt + 4'h1 >= CNT_W'(ctl_r.oe_n ? WRITE_PULSE_CYC :
                (FLOAT_SETUP_CYC > WRITE_PULSE_CYC ? FLOAT_SETUP_CYC : WRITE_PULSE_CYC)))
            begin
               // Strobe rises, data still driven one cycle for hold
               ctl_nxt.we_n = 1'b1;
               ctl_nxt.st = DONE;
            end
         end
         DONE:
         begin
            // Select and data released after strobe is high
            ctl_nxt.sel_n = 1'b1;
            ctl_nxt.oe_n = 1'b1;
            ctl_nxt.drv_n = 1'b1;
            ctl_nxt.st = IDLE;
         end
         default:
         begin
            ctl_nxt = CTL_RST;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
         ctl_r <= CTL_RST;
      else
         ctl_r <= ctl_nxt;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Same-location collisions across ports are the system's duty
   assign req_ready = (ctl_r.st == IDLE);
   assign rsp_valid = ctl_r.rv;
   assign rsp_rdata = ctl_r.rdata;
   assign port_addr_lines = ctl_r.addr;
   assign port_sel_n = ctl_r.sel_n;
   assign port_we_n = ctl_r.we_n;
   assign port_oe_n = ctl_r.oe_n;
   assign port_data_out = ctl_r.wdata;
   assign port_data_oe_n = ctl_r.drv_n;
endmodule : dp_sram_host
`default_nettype wire

// ### testbench/dp_sram_host_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dp_sram_host_checker
   import dp_sram_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic [ADDR_W-1:0] port_addr_lines,
   input wire logic              port_sel_n,
   input wire logic              port_we_n,
   input wire logic              port_oe_n,
   input wire logic [DATA_W-1:0] port_data_out,
   input wire logic              port_data_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   read_we_a: assert property (!port_sel_n && port_data_oe_n |-> port_we_n)
      else $error("strobe low in read");
   addr_sel_a: assert property ($fell(port_sel_n) |-> $stable(port_addr_lines))
      else $error("address moved at select");
   addr_we_a: assert property ($changed(port_addr_lines) |-> port_we_n && $past(port_we_n))
      else $error("address moved in write");
   data_hold_a: assert property ($rose(port_we_n) |->
      !port_sel_n && !port_data_oe_n && $stable(port_data_out))
      else $error("data not held at write end");
   pulse_drv_a: assert property ($fell(port_we_n) && !port_oe_n |=> port_we_n ##1 port_sel_n)
      else $error("bad pulse with drive low");
   pulse_min_a: assert property ($fell(port_we_n) && port_oe_n |=> port_we_n)
      else $error("bad pulse with drive high");
   drive_sel_a: assert property (!port_data_oe_n |-> !port_sel_n)
      else $error("data driven unselected");
endmodule : dp_sram_host_checker
bind dp_sram_host dp_sram_host_checker dp_sram_host_checker_i (.clk, .rst_n,
   .port_addr_lines, .port_sel_n, .port_we_n, .port_oe_n, .port_data_out, .port_data_oe_n);
`default_nettype wire

// ### testbench/dp_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module dp_sram_model
   import dp_sram_pkg::*;
#(parameter int DLY = 0)
(
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              sel_n,
   input  wire logic              we_n,
   input  wire logic              oe_n,
   input  wire logic [DATA_W-1:0] din,
   output logic      [DATA_W-1:0] dout,
   output logic                   drive
);
   logic [DATA_W-1:0] mem [1<<ADDR_W];
   wire logic         wr = !sel_n && !we_n;
   always @(negedge wr) mem[addr] = din;
   assign drive = !sel_n && we_n && !oe_n;
   // Released lines show the inverse, never a stale copy
   assign #(DLY) dout = drive ? mem[addr] : ~mem[addr];
endmodule : dp_sram_model
`default_nettype wire

// ### testbench/dp_sram_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dp_sram_host_tb
   import dp_sram_pkg::*;
;
   logic clk = 0, rst_n = 0, req_valid = 0, req_write = 0, req_hold_drive = 0, rh;
   logic req_ready, rsp_valid, port_sel_n, port_we_n, port_oe_n, port_data_oe_n, drive;
   logic [ADDR_W-1:0] req_addr = '0, port_addr_lines, ra;
   logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, port_data_out, dout, rd;
   logic [DATA_W-1:0] ref_mem [1<<ADDR_W];
   logic [DATA_W-1:0] exp_q [$];
   int                fail_count = 0, cmp_count = 0;
   wire logic [DATA_W-1:0] port_data_in = port_data_oe_n ? dout : port_data_out;
   dp_sram_host dp_sram_host_i (.clk, .rst_n, .req_valid, .req_write, .req_hold_drive,
      .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .port_addr_lines,
      .port_sel_n, .port_we_n, .port_oe_n, .port_data_in, .port_data_out, .port_data_oe_n);
   // Slow device: read data lags by the whole access time
   dp_sram_model #(.DLY(15)) dp_sram_model_i (.addr(port_addr_lines), .sel_n(port_sel_n),
      .we_n(port_we_n), .oe_n(port_oe_n), .din(port_data_out), .dout, .drive);
   initial forever #12.5 clk = ~clk;
   task chk(string n, logic [DATA_W-1:0] g, logic [DATA_W-1:0] e);
      cmp_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // Valid stays up between requests; fields change only once taken
   task op(logic w, logic h, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      {req_valid, req_write, req_hold_drive, req_addr, req_wdata} = {1'b1, w, h, a, d};
      if (w)
         ref_mem[a] = d;
      else
         exp_q.push_back(ref_mem[a]);
      while (req_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      // Drive mode is read one cycle after the take, so fields stand a cycle longer
      @(negedge clk);
   endtask : op
   always @(negedge clk)
      if (rsp_valid === 1'b1)
         chk("rdata", rsp_rdata, exp_q.pop_front());
   task stop_test;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   initial
   begin
      void'($urandom(32'hD20AC2FF));
      repeat (6) @(negedge clk);
      rst_n = 1;
      repeat (3) @(negedge clk);
      op(1, 0, 12'h000, 8'h5A);
      op(1, 1, 12'hFFF, 8'hC3);
      op(0, 0, 12'hFFF, 8'h00);
      op(0, 1, 12'h000, 8'h00);
      $display("edge test done");
      for (int i = 0; i < 40; i++)
      begin
         {rh, ra, rd} = 21'($urandom);
         op(1, rh, ra, rd);
         op(1, !rh, ra, ~rd);
         op(0, rh, ra, 8'h00);
      end
      req_valid = 0;
      repeat (12) @(negedge clk);
      chk("pending", 8'(exp_q.size()), 8'h00);
      $display("random test done");
      stop_test();
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      fail_count++;
      stop_test();
   end
endmodule : dp_sram_host_tb
`default_nettype wire
